// ### hdl/ifc_defs.svh
`ifndef IFC_DEFS_SVH
`define IFC_DEFS_SVH

// Clock period and the 1 kHz time base that paces the gate.
`define IFC_CLK_NS        10
`define IFC_TIMEBASE_NS   1000000
`define IFC_TICK_CYCLES   (`IFC_TIMEBASE_NS / `IFC_CLK_NS)

// Counter width and the stability count of the noise canceller.
`define IFC_COUNT_W       20
`define IFC_NC_CYCLES     4'h8

// Source select codes.
`define IFC_SRC_AMP       2'h0
`define IFC_SRC_PORT      2'h1
`define IFC_SRC_PRESC     2'h2

// Gate lengths in 1 kHz periods for each gate select code.
`define IFC_GATE_0        5'h01
`define IFC_GATE_1        5'h04
`define IFC_GATE_2        5'h08
`define IFC_GATE_3        5'h10

// Reset values.
`define IFC_RST_COUNT     20'h00000

`endif

// ### hdl/ifc_pkg.sv
package ifc_pkg;

    // Measurement sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_COUNT
    } ifc_state_t;

endpackage

// ### hdl/if_frequency_counter.sv
`timescale 1ns/10ps
`include "ifc_defs.svh"

// What this block does
// - Twenty-bit counter of source pulses during gate
// - Port source takes CMOS input, no amplifier
// - Amplifier off when PLL is off
// - High-band prescaler source divided by sixteen
// - Low-band prescaler source counted undivided
// - Enable bit starts amplifier and counter
// - Noise canceller narrows range when selected
// - Auto mode counts gate time then stops
// - Busy flag high during a measurement
// - Overflow set at two-to-twenty pulses
// - Manual mode: run starts, clearing run latches
// - Counter advances on rising input edges
// - Control state survives PLL supply off
// - Gate opens on next 1 kHz tick
module if_frequency_counter
    import ifc_pkg::*;
#(
    parameter int TICK_CYCLES = `IFC_TICK_CYCLES
)
(
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Control bits from software.
    input  wire logic                    count_run_bit,
    input  wire logic                    manual_mode,
    input  wire logic [1:0]              gate_sel,
    input  wire logic [1:0]              src_sel,
    input  wire logic                    ifreq_enable,
    input  wire logic                    noise_cancel,
    // Tuner side.
    input  wire logic                    pll_off,
    input  wire logic                    high_band_pll_mode,
    input  wire logic                    intermediate_freq_pin,
    input  wire logic                    port_in,
    input  wire logic                    local_osc_pin,
    // Status and result.
    output logic                         ifreq_amp_on,
    output logic                         busy,
    output logic                         overflow,
    output logic [`IFC_COUNT_W-1:0]      count_result_bits
);

    initial
    begin
        if (TICK_CYCLES < 2 || TICK_CYCLES > 131071)
            $error("TICK_CYCLES out of range for the time base divider.");
    end

    // Gate length in 1 kHz periods for a gate select code.
    function automatic logic [4:0] gate_len(input logic [1:0] code);
        logic [4:0] len;
        len = `IFC_GATE_0;
        case (code)
            2'h1: len = `IFC_GATE_1;
            2'h2: len = `IFC_GATE_2;
            2'h3: len = `IFC_GATE_3;
            default: len = `IFC_GATE_0;
        endcase
        return len;
    endfunction

    typedef struct packed {
        ifc_state_t              st;
        logic [16:0]             tick_cnt;
        logic [4:0]              gate_left;
        logic [`IFC_COUNT_W-1:0] count;
        logic                    over;
        logic [`IFC_COUNT_W-1:0] result;
        logic                    run_d;
        logic                    osc_d;
        logic [3:0]              presc;
        logic                    filt;
        logic [3:0]              filt_cnt;
        logic                    src_d;
        logic                    amp_on;
    } ifc_regs_t;

    ifc_regs_t s_r;
    ifc_regs_t s_nxt;

    logic tick;
    logic raw_src;
    logic pulse;
    logic start;

    // Source mux, edge detect and tick decode are shared by the sequencer and the checks.
    always_comb
    begin
        tick = (s_r.tick_cnt == 17'(TICK_CYCLES - 1));
        if (src_sel == `IFC_SRC_PORT)
            raw_src = port_in;
        else if (src_sel == `IFC_SRC_PRESC)
            raw_src = high_band_pll_mode ? s_r.presc[3]
                                         : local_osc_pin;
        else
            raw_src = intermediate_freq_pin & s_r.amp_on;
        pulse = s_r.filt & ~s_r.src_d;
        start = count_run_bit & ~s_r.run_d & ifreq_enable;
    end

    // Next state of the whole block.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.run_d = count_run_bit;
        s_nxt.osc_d = local_osc_pin;
        s_nxt.src_d = s_r.filt;
        // The amplifier only runs when selected, enabled and the PLL is powered.
        // Code 3 is treated as the amplified input, so it must power the amplifier too.
        s_nxt.amp_on = ifreq_enable & ~pll_off
                     & (src_sel != `IFC_SRC_PORT) & (src_sel != `IFC_SRC_PRESC);
        s_nxt.tick_cnt = tick ? 17'h00000 : s_r.tick_cnt + 17'h00001;
        // Prescaler MSB toggles every eight oscillator edges, one rise per sixteen.
        if (local_osc_pin & ~s_r.osc_d)
            s_nxt.presc = s_r.presc + 4'h1;
        // With the canceller on, a level must hold for a run of cycles; this
        // rejects short glitches but caps the usable rate well below the plain path.
        if (!noise_cancel)
        begin
            s_nxt.filt = raw_src;
            s_nxt.filt_cnt = 4'h0;
        end
        else if (raw_src == s_r.filt)
            s_nxt.filt_cnt = 4'h0;
        else if (s_r.filt_cnt == `IFC_NC_CYCLES - 4'h1)
        begin
            s_nxt.filt = raw_src;
            s_nxt.filt_cnt = 4'h0;
        end
        else
            s_nxt.filt_cnt = s_r.filt_cnt + 4'h1;
        // Sequencer; pll_off does not touch it so control state is kept.
        case (s_r.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    s_nxt.st = ST_WAIT;
                    s_nxt.count = `IFC_RST_COUNT;
                    s_nxt.over = 1'b0;
                    s_nxt.gate_left = gate_len(gate_sel);
                end
            end
            ST_WAIT:
            begin
                if (manual_mode && !count_run_bit)
                begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.result = s_r.count;
                end
                else if (tick)
                    s_nxt.st = ST_COUNT;
            end
            ST_COUNT:
            begin
                if (pulse)
                begin
                    s_nxt.count = s_r.count + 20'h00001;
                    if (&s_r.count)
                        s_nxt.over = 1'b1;
                end
                if (manual_mode)
                begin
                    if (!count_run_bit)
                    begin
                        s_nxt.st = ST_IDLE;
                        s_nxt.result = s_r.count;
                    end
                end
                else if (tick)
                begin
                    if (s_r.gate_left == 5'h01)
                    begin
                        s_nxt.st = ST_IDLE;
                        s_nxt.result = s_r.count;
                    end
                    else
                        s_nxt.gate_left = s_r.gate_left - 5'h01;
                end
            end
            default:
                s_nxt.st = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs come straight from the state register.
    assign busy = (s_r.st != ST_IDLE);
    assign overflow = s_r.over;
    assign count_result_bits = s_r.result;
    assign ifreq_amp_on = s_r.amp_on;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    busy_on_start_a: assert property (s_r.st == ST_IDLE && start |=> busy)
        else $error("Busy did not rise after start.");
    count_clear_a: assert property (s_r.st == ST_IDLE && start |=> s_r.count == 20'h00000 && !overflow)
        else $error("Start did not clear count and overflow.");
    gate_open_a: assert property (s_r.st == ST_WAIT && tick && !manual_mode |=> s_r.st == ST_COUNT)
        else $error("Gate did not open on the tick.");
    auto_stop_a: assert property (s_r.st == ST_COUNT && !manual_mode && tick
                                  && s_r.gate_left == 5'h01 |=> !busy
                                  && count_result_bits == $past(s_r.count))
        else $error("Auto gate did not stop and latch.");
    manual_stop_a: assert property (s_r.st == ST_COUNT && manual_mode && !count_run_bit
                                    |=> !busy && count_result_bits == $past(s_r.count))
        else $error("Manual stop did not end the measurement.");
    count_step_a: assert property (s_r.st == ST_COUNT && pulse |=> s_r.count == $past(s_r.count) + 20'h00001)
        else $error("Counter missed a pulse.");
    count_hold_a: assert property (s_r.st == ST_COUNT && !pulse |=> s_r.count == $past(s_r.count))
        else $error("Counter moved without a rising edge.");
    overflow_set_a: assert property (s_r.st == ST_COUNT && pulse && &s_r.count |=> overflow)
        else $error("Overflow not set at wrap.");
    amp_off_a: assert property (pll_off |=> !ifreq_amp_on)
        else $error("Amplifier on while PLL off.");

    auto_done_c: cover property (s_r.st == ST_COUNT && !manual_mode ##1 s_r.st == ST_IDLE);
    manual_done_c: cover property (s_r.st == ST_COUNT && manual_mode ##1 s_r.st == ST_IDLE);
    overflow_c: cover property ($rose(overflow));

endmodule

// ### test/tuner_model.sv
`timescale 1ns/10ps
module tuner_model
(
    // Bench clock.
    ref_clk,
    // Pulse lines towards the counter.
    intermediate_freq_pin,
    port_in,
    local_osc_pin
);
    input  wire logic ref_clk;
    output logic      intermediate_freq_pin;
    output logic      port_in;
    output logic      local_osc_pin;

    // Idle lines rest low, so a burst always ends on a falling edge.
    initial
    begin
        intermediate_freq_pin = 1'b0;
        port_in = 1'b0;
        local_osc_pin = 1'b0;
    end

    // Sends n pulses on one line, each level held for half cycles.
    task automatic send(input int pin, input int n, input int half);
        for (int i = 0; i < 2 * n; i++)
        begin
            @(posedge ref_clk);
            // Code 3 drives the IF line, as the counter reads it as the amplified input.
            if (pin == 0 || pin == 3)
                intermediate_freq_pin <= ~intermediate_freq_pin;
            else if (pin == 1)
                port_in <= ~port_in;
            else
                local_osc_pin <= ~local_osc_pin;
            repeat (half - 1) @(posedge ref_clk);
        end
    endtask
endmodule

// ### test/if_frequency_counter_tb.sv
`timescale 1ns/10ps
module if_frequency_counter_tb;
    logic        ref_clk, rst, count_run_bit, manual_mode, ifreq_enable, noise_cancel;
    logic        pll_off, high_band_pll_mode, intermediate_freq_pin, port_in, local_osc_pin;
    logic        ifreq_amp_on, busy, overflow;
    logic [1:0]  gate_sel, src_sel;
    logic [19:0] result;
    int          failures, checks_done;

    // Short time base: one 1 kHz tick lasts 20 cycles here.
    if_frequency_counter #(.TICK_CYCLES(20)) i_if_frequency_counter
    (
        .ref_clk(ref_clk), .rst(rst), .count_run_bit(count_run_bit),
        .manual_mode(manual_mode), .gate_sel(gate_sel), .src_sel(src_sel),
        .ifreq_enable(ifreq_enable), .noise_cancel(noise_cancel), .pll_off(pll_off),
        .high_band_pll_mode(high_band_pll_mode), .intermediate_freq_pin(intermediate_freq_pin),
        .port_in(port_in), .local_osc_pin(local_osc_pin), .ifreq_amp_on(ifreq_amp_on),
        .busy(busy), .overflow(overflow), .count_result_bits(result)
    );

    tuner_model i_tuner_model
    (
        .ref_clk(ref_clk), .intermediate_freq_pin(intermediate_freq_pin),
        .port_in(port_in), .local_osc_pin(local_osc_pin)
    );

    // Free running 100 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Manual run: pulses go in only once the gate is surely open.
    task automatic measure(input logic [1:0] s, input logic hb, input int n, input int half,
                           input logic [19:0] exp);
        @(posedge ref_clk);
        src_sel <= s;
        high_band_pll_mode <= hb;
        manual_mode <= 1'b1;
        @(posedge ref_clk);
        count_run_bit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(busy, 1'b1);
        repeat (25) @(posedge ref_clk);
        i_tuner_model.send(s, n, half);
        repeat (20) @(posedge ref_clk);
        count_run_bit <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(busy, 1'b0);
        check(overflow, 1'b0);
        check(result, exp);
    endtask

    task automatic t_amp();
        @(posedge ref_clk);
        check({18'h00000, overflow, busy}, 20'h00000);
        check(result, 20'h00000);
        count_run_bit <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(busy, 1'b0);
        count_run_bit <= 1'b0;
        ifreq_enable <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(ifreq_amp_on, 1'b1);
        pll_off <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(ifreq_amp_on, 1'b0);
        pll_off <= 1'b0;
        $display("amplifier test done");
    endtask

    task automatic t_sources();
        measure(2'h0, 1'b0, 5, 3, 20'h00005);
        measure(2'h3, 1'b0, 3, 3, 20'h00003);
        // The port source must keep counting with the PLL switched off.
        pll_off <= 1'b1;
        measure(2'h1, 1'b0, 7, 3, 20'h00007);
        pll_off <= 1'b0;
        measure(2'h2, 1'b0, 9, 3, 20'h00009);
        measure(2'h2, 1'b1, 32, 3, 20'h00002);
        measure(2'h1, 1'b0, 0, 3, 20'h00000);
        noise_cancel <= 1'b1;
        measure(2'h1, 1'b0, 4, 12, 20'h00004);
        measure(2'h1, 1'b0, 6, 3, 20'h00000);
        noise_cancel <= 1'b0;
        $display("source test done");
    endtask

    // Dropping run in automatic mode must not cut the gate short.
    task automatic t_auto();
        int len[4] = '{1, 4, 8, 16};
        int cyc;
        manual_mode <= 1'b0;
        for (int g = 0; g < 4; g++)
        begin
            @(posedge ref_clk);
            gate_sel <= g[1:0];
            count_run_bit <= 1'b1;
            @(posedge ref_clk);
            count_run_bit <= 1'b0;
            cyc = 0;
            @(posedge ref_clk);
            // Longer gates get three port pulses once the gate is surely open.
            if (g > 0)
            begin
                repeat (24) @(posedge ref_clk);
                i_tuner_model.send(1, 3, 3);
                cyc = 42;
            end
            while (busy === 1'b1 && cyc < 400)
            begin
                @(posedge ref_clk);
                cyc++;
            end
            check(cyc >= len[g] * 20 + 1 && cyc <= len[g] * 20 + 20, 1'b1);
            check(overflow, 1'b0);
            check(result, (g > 0) ? 20'h00003 : 20'h00000);
        end
        $display("automatic test done");
    endtask

    // Main sequence. The control top bit and the gain register sit outside this
    // block, so software holding them at zero and all ones needs no stimulus.
    initial
    begin
        {rst, count_run_bit, manual_mode, ifreq_enable, noise_cancel} = 5'h10;
        {pll_off, high_band_pll_mode, gate_sel, src_sel} = 6'h00;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        t_amp();
        t_sources();
        t_auto();
        wrap_up();
    end

    // Watchdog; the tests need under 3000 cycles.
    initial
    begin
        repeat (6000) @(posedge ref_clk);
        failures++;
        wrap_up();
    end
endmodule
